// ===== testbench/wdat_cpu_model.sv
// cpu-side partner: issues instruction fetches and takes irq/reset events
`timescale 1ns/1ps
`default_nettype none
module wdat_cpu_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        go,
   input  wire logic [15:0] go_addr,
   output logic             fetch_valid,
   output logic [15:0]      fetch_addr,
   input  wire logic        guard_overflow_irq,
   input  wire logic        fetch_trap_irq,
   input  wire logic        sys_reset_req,
   input  wire logic        hf_osc_restart,
   output int               n_wirq,
   output int               n_tirq,
   output int               n_osc,
   output int               n_rst,
   output int               rst_len
);
   // counters start at zero as int variables do
   int run_len;

   // one fetch per go cycle; idle address inverts so no stale value lingers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fetch_valid <= 1'b0;
         fetch_addr  <= 16'hFFFF;
      end else begin
         fetch_valid <= go;
         fetch_addr  <= go ? go_addr : ~fetch_addr;
      end
   end

   // stack is taken as set up before any irq; nmis are taken at once
   always @(posedge clk) begin
      if (guard_overflow_irq === 1'b1) n_wirq <= n_wirq + 1;
      if (fetch_trap_irq === 1'b1) n_tirq <= n_tirq + 1;
      if (hf_osc_restart === 1'b1) n_osc <= n_osc + 1;
      // length is recorded when the request falls
      if (sys_reset_req === 1'b1) begin
         run_len <= run_len + 1;
      end else if (run_len != 0) begin
         rst_len <= run_len;
         n_rst <= n_rst + 1;
         run_len <= 0;
      end
   end
endmodule
`default_nettype wire

// ===== testbench/wdat_guard_tb.sv
// self-checking bench for the watchdog and address-trap block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin n_errors++; \
   $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module wdat_guard_tb;
   logic             clk, rst, fs_tick, lsm1, go, sps;
   logic             awvalid, wvalid, bready, arvalid, rready;
   logic [31:0]      awaddr, wdata, araddr, rd;
   logic [15:0]      go_addr, a;
   logic [1:0]       rs;
   wire logic        awready, wready, bvalid, arready, rvalid;
   wire logic        wirq, tirq, rreq, osc, fvalid;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [15:0] faddr;
   int               n_errors, checked, seed, cyc, b, c, e_t;
   int               nw, nt, no, nr, rlen, k;

   // slow exponent must cover code 11 without going negative
   wdat_guard #(.FC_LOG2(6), .FS_LOG2(6)) i_dut (
      .clk(clk), .rst(rst), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .fs_tick(fs_tick), .slow_prescale_sel(sps),
      .low_speed_mode_1(lsm1), .fetch_valid(fvalid), .fetch_addr(faddr),
      .guard_overflow_irq(wirq), .fetch_trap_irq(tirq),
      .sys_reset_req(rreq), .hf_osc_restart(osc));

   wdat_cpu_model i_cpu (.clk(clk), .rst(rst), .go(go), .go_addr(go_addr),
      .fetch_valid(fvalid), .fetch_addr(faddr), .guard_overflow_irq(wirq),
      .fetch_trap_irq(tirq), .sys_reset_req(rreq), .hf_osc_restart(osc),
      .n_wirq(nw), .n_tirq(nt), .n_osc(no), .n_rst(nr), .rst_len(rlen));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // random slow ticks; cycle ceiling cuts a hang short
   always @(posedge clk) begin
      cyc <= cyc + 1;
      fs_tick <= ($random(seed) & 3) == 0;
      if (cyc == 20000) begin
         n_errors++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("counts: %0d checks, %0d mismatches", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic clk_n(input int n);
      repeat (n) @(posedge clk);
   endtask

   // write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge clk);
      awvalid <= 1'b1;
      awaddr <= {24'h00_0000, ad};
      wvalid <= 1'b1;
      wdata <= d;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] ad);
      @(posedge clk);
      arvalid <= 1'b1;
      araddr <= {24'h00_0000, ad};
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask

   task automatic fetch(input logic [15:0] fa);
      @(posedge clk);
      go <= 1'b1;
      go_addr <= fa;
      @(posedge clk);
      go <= 1'b0;
      clk_n(4);
   endtask

   // expected trap count of one fetch
   function automatic int traps(input logic [15:0] fa, input logic live);
      return (fa <= 16'h003F || (live && fa >= 16'h0040 && fa <= 16'h023F));
   endfunction

   // in each group of eight, boundary addresses first, then random ones of each class
   function automatic logic [15:0] pick(input int i);
      logic [15:0] cor [4] = '{16'h003F, 16'h0040, 16'h023F, 16'h0240};
      if (i % 8 < 4) return cor[i % 4];
      case ($random(seed) & 3)
         0: return 16'($random(seed) & 16'h003F);
         1: return 16'h0040 + 16'($random(seed) & 16'h01FF);
         default: return 16'h0300 + 16'($random(seed) & 16'h00FF);
      endcase
   endfunction

   // overflow must land between three and four quarters of a period
   function automatic logic win_ok(input int cy, input int p);
      return cy >= (3 << (6 - 2 * p)) - 2 && cy <= (4 << (6 - 2 * p)) + 3;
   endfunction

   initial begin
      seed = 72000;
      cyc = 0;
      n_errors = 0;
      checked = 0;
      e_t = 0;
      {rst, go, go_addr, lsm1, sps} = {1'b1, 19'h0_0000};
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, wdata, araddr} = 96'h0;
      clk_n(10);
      rst <= 1'b0;
      rd_reg(8'h08);
      `CHK("status", 11'h0F9, rd[10:0])
      rd_reg(8'h0C);
      `CHK("unmapped", 2'h2, rs)
      wr(8'h0C, 32'h0000_0000);
      `CHK("wr unmapped", 2'h2, rs)
      $display("test reset done");
      // stack ready; one write sets irq mode and stages ram trap off
      wr(8'h00, 32'h0000_0008);
      `CHK("wr resp", 2'h0, rs)
      for (int i = 0; i < 16; i++) begin
         if (i == 8) wr(8'h04, 32'h0000_00D2);
         a = pick(i);
         fetch(a);
         e_t += traps(a, i < 8);
         `CHK("trap irqs", e_t, nt)
      end
      $display("test traps done");
      wr(8'h00, 32'h0000_0009);
      rd_reg(8'h08);
      `CHK("ovf sel", 1'b0, rd[0])
      for (int p = 0; p < 4; p++) begin
         wr(8'h00, 32'(8 + 2 * p));
         wr(8'h04, 32'h0000_004E);
         b = nw;
         c = 0;
         while (nw == b) begin
            @(posedge clk);
            c++;
         end
         `CHK("ovf window", 1'b1, win_ok(c, p))
         clk_n(2);
         `CHK("one irq", b + 1, nw)
      end
      // slow prescale: at the shortest code every slow tick counts
      sps <= 1'b1;
      wr(8'h00, 32'h0000_000E);
      wr(8'h04, 32'h0000_004E);
      b = nw;
      k = 0;
      while (nw == b) begin
         @(posedge clk);
         k += fs_tick;
      end
      `CHK("fs ovf ticks", 1'b1, k >= 3 && k <= 6)
      sps <= 1'b0;
      $display("test periods done");
      wr(8'h04, 32'h0000_00B1);
      rd_reg(8'h08);
      `CHK("still running", 1'b1, rd[7])
      // irq flag already off: clear, enable 0, disable code
      wr(8'h04, 32'h0000_004E);
      wr(8'h00, 32'h0000_0006);
      wr(8'h04, 32'h0000_00B1);
      // an overflow in the disable cycle is still being counted
      clk_n(2);
      b = nw;
      clk_n(300);
      rd_reg(8'h08);
      `CHK("stopped", 3'h0, {rd[7], rd[9:8]})
      `CHK("no irq off", b, nw)
      $display("test disable done");
      lsm1 <= 1'b1;
      rst <= 1'b1;
      clk_n(2);
      rst <= 1'b0;
      b = nr;
      c = no;
      fetch(16'h0010);
      while (nr == b) @(posedge clk);
      `CHK("trap rst len", 24, rlen)
      `CHK("osc restart", c + 1, no)
      lsm1 <= 1'b0;
      rst <= 1'b1;
      clk_n(2);
      rst <= 1'b0;
      b = nr;
      c = no;
      wr(8'h00, 32'h0000_003F);
      while (nr == b) @(posedge clk);
      `CHK("wdt rst len", 24, rlen)
      `CHK("no osc fast", c, no)
      $display("test resets done");
      end_of_test();
   end
endmodule
`default_nettype wire

// ===== verilog/wdat_guard.sv
// watchdog timer with address-trap monitor, AXI4-Lite register slave
// Operation
// R1 - enable bit resets to 1, so the watchdog counts right after reset
// R2 - software stops it: irq flag off, clear code, enable 0, disable code
// R3 - disable code acts only while the enable bit is already 0
// R4 - while disabled, the binary counter is held cleared
// R5 - clear code clears the binary counter only, not the prescale divider
// R6 - period field picks four periods, each a quarter of the one before
// R7 - overflow with action select 0 raises the watchdog interrupt
// R8 - once action select is 0, writes cannot set it back to 1
// R9 - watchdog interrupt is non-maskable, global enable flag ignored
// R10 - a new watchdog interrupt preempts any service in progress
// R11 - software sets the stack pointer before selecting interrupt output
// R12 - overflow with action select 1 raises a hardware reset request
// R13 - watchdog or trap reset lasts at most 24 high-frequency periods
// R14 - reset in low speed mode 1 restarts the fast oscillator
// R15 - watchdog and trap control bits share registers, one write sets both
// R16 - new ram trap enable takes effect only after the arm code
// R17 - software clears ram trap enable before running code from ram
// R18 - fetch from the special register area always traps
// R19 - trap with trap action 0 raises the trap interrupt
// R20 - trap with trap action 1 raises a hardware reset request
// R21 - trap interrupt is non-maskable, global enable flag ignored
// R22 - a new trap interrupt preempts any service in progress
// R23 - software sets the stack pointer before enabling trap interrupts
// R24 - each overflow or trapped fetch issues one request; reset-action overflow and trap in one cycle share one; a reset raised during a reset issues none
//
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module wdat_guard #(
   parameter int          FC_LOG2  = 23,
   parameter int          FS_LOG2  = 15,
   parameter logic [15:0] RAM_BASE = 16'h0040,
   parameter logic [15:0] RAM_LAST = 16'h023F,
   parameter logic [15:0] SFR_BASE = 16'h0000,
   parameter logic [15:0] SFR_LAST = 16'h003F
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [31:0] s_axi_araddr,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   input  wire logic        fs_tick,
   input  wire logic        slow_prescale_sel,
   input  wire logic        low_speed_mode_1,
   input  wire logic        fetch_valid,
   input  wire logic [15:0] fetch_addr,
   output logic             guard_overflow_irq,
   output logic             fetch_trap_irq,
   output logic             sys_reset_req,
   output logic             hf_osc_restart
);
   wdat_pkg::wdat_state_t s;
   wdat_pkg::wdat_state_t n;

   logic       wr_go;
   logic       wr_a;
   logic       wr_b;
   logic       use_fs;
   logic       src_en;
   logic [4:0] lg;
   logic       tick;
   logic       clr_cmd;
   logic       ovf;
   logic       hit_sfr;
   logic       hit_ram;
   logic       trap;
   logic       start_rst;

   // true once every divider bit below lg is one
   function automatic logic tick_hit(input logic [wdat_pkg::DIV_W-1:0] d,
                                     input logic [4:0] l);
      logic [wdat_pkg::DIV_W-1:0] m;
      m = ~({wdat_pkg::DIV_W{1'b1}} << l);
      return (d & m) == m;
   endfunction

   function automatic logic in_rng(input logic [15:0] a,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction

   // write path decode; upper address bits are not decoded
   assign wr_go   = s.aw_full & s.w_full & ~s.bvalid;
   assign wr_a    = wr_go & s.w_en & (s.aw_addr == wdat_pkg::OFF_CTRL_A);
   assign wr_b    = wr_go & s.w_en & (s.aw_addr == wdat_pkg::OFF_CMD_B);
   assign clr_cmd = wr_b & (s.w_data == wdat_pkg::CODE_CLEAR);

   // prescale source: slow clock ticks in low speed or when selected
   assign use_fs = low_speed_mode_1 | slow_prescale_sel;
   assign src_en = use_fs ? fs_tick : 1'b1;
   // each period code divides the tick interval by four
   assign lg = use_fs ? 5'(FS_LOG2 - 2 * int'(s.period))
                      : 5'(FC_LOG2 - 2 * int'(s.period)); // R6
   assign tick = s.run & src_en & tick_hit(s.div, lg);
   // a clear in the same cycle beats the overflow
   assign ovf = tick & (s.bin == 2'h3) & ~clr_cmd;

   // trap monitor: register area always, ram only when armed
   assign hit_sfr = in_rng(fetch_addr, SFR_BASE, SFR_LAST); // R18
   assign hit_ram = s.trap_live & in_rng(fetch_addr, RAM_BASE, RAM_LAST);
   assign trap    = fetch_valid & (hit_sfr | hit_ram); // R19 R20
   // a request raised while reset is already asserted is absorbed by it
   assign start_rst = ~s.rst_out & ((ovf & s.ovf_sel) | (trap & s.trap_act));

   // next state of the whole block
   always_comb begin
      n      = s;
      n.wirq = 1'b0;
      n.tirq = 1'b0;
      n.osc_out = 1'b0;
      // bus: take address and data independently
      if (s.aw_rdy && s_axi_awvalid) begin
         n.aw_full = 1'b1;
         n.aw_addr = s_axi_awaddr[7:0];
      end
      if (s.w_rdy && s_axi_wvalid) begin
         n.w_full = 1'b1;
         n.w_data = s_axi_wdata[7:0];
         n.w_en   = s_axi_wstrb[0];
      end
      if (s.bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
      end
      if (wr_go) begin
         n.aw_full = 1'b0;
         n.w_full  = 1'b0;
         n.bvalid  = 1'b1;
         if (s.aw_addr == wdat_pkg::OFF_CTRL_A ||
             s.aw_addr == wdat_pkg::OFF_CMD_B ||
             s.aw_addr == wdat_pkg::OFF_STATUS) begin
            n.bresp = wdat_pkg::RESP_OKAY;
         end else begin
            n.bresp = wdat_pkg::RESP_SLVERR;
         end
      end
      // one write sets watchdog and trap fields together
      if (wr_a) begin // R15
         n.ovf_sel    = s.ovf_sel & s.w_data[wdat_pkg::POS_OVF_SEL]; // R8
         n.period     = s.w_data[wdat_pkg::POS_PERIOD +: 2];
         n.en_bit     = s.w_data[wdat_pkg::POS_EN_BIT];
         n.trap_act   = s.w_data[wdat_pkg::POS_TRAP_ACT];
         n.trap_stage = s.w_data[wdat_pkg::POS_TRAP_EN];
         if (s.w_data[wdat_pkg::POS_EN_BIT]) begin
            n.run = 1'b1; // R1
         end
      end
      // commands
      if (wr_b && s.w_data == wdat_pkg::CODE_DISABLE && !s.en_bit) begin
         n.run = 1'b0; // R3
      end
      if (wr_b && s.w_data == wdat_pkg::CODE_ARM) begin
         n.trap_live = s.trap_stage; // R16
      end
      // read channel; control registers are write-only and read zero
      if (s.rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
      end
      if (s.ar_rdy && s_axi_arvalid) begin
         n.rvalid = 1'b1;
         n.rdata  = 32'h0000_0000;
         n.rresp  = wdat_pkg::RESP_OKAY;
         unique case (s_axi_araddr[7:0])
            wdat_pkg::OFF_CTRL_A, wdat_pkg::OFF_CMD_B: begin
               n.rdata = 32'h0000_0000;
            end
            wdat_pkg::OFF_STATUS: begin
               n.rdata = {21'h0, s.rst_out, s.bin, s.run, s.trap_live,
                          s.trap_stage, s.trap_act, s.en_bit, s.period,
                          s.ovf_sel};
            end
            default: begin
               n.rresp = wdat_pkg::RESP_SLVERR;
            end
         endcase
      end
      n.aw_rdy = ~n.aw_full;
      n.w_rdy  = ~n.w_full;
      n.ar_rdy = ~n.rvalid;
      // divider runs free; clear code leaves it alone, hence 3/4 periods
      if (src_en) begin
         n.div = s.div + 1'b1; // R5
      end
      // an honoured disable clears at once, so no stale count survives
      if (!s.run || !n.run || clr_cmd) begin
         n.bin = 2'h0; // R4 R5
      end else if (tick) begin
         n.bin = s.bin + 2'h1;
      end
      // one pulse per event, never gated by the cpu irq enable flag
      n.wirq = ovf & ~s.ovf_sel; // R7 R9 R10 R24
      n.tirq = trap & ~s.trap_act; // R19 R21 R22 R24
      // reset request of fixed length in fast clock periods
      if (start_rst) begin
         n.rst_cnt = wdat_pkg::RST_CYCLES; // R12 R20 R13
         n.osc_out = low_speed_mode_1; // R14
      end else if (s.rst_cnt != 5'h0) begin
         n.rst_cnt = s.rst_cnt - 5'h1;
      end
      n.rst_out = n.rst_cnt != 5'h0; // R13
   end

   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s            <= '0;
         s.aw_rdy     <= 1'b1;
         s.w_rdy      <= 1'b1;
         s.ar_rdy     <= 1'b1;
         s.ovf_sel    <= wdat_pkg::RST_OVF_SEL;
         s.period     <= wdat_pkg::RST_PERIOD;
         s.en_bit     <= wdat_pkg::RST_EN_BIT; // R1
         s.run        <= wdat_pkg::RST_EN_BIT;
         s.trap_act   <= wdat_pkg::RST_TRAP_ACT;
         s.trap_stage <= wdat_pkg::RST_TRAP_EN;
         s.trap_live  <= wdat_pkg::RST_TRAP_EN;
      end else begin
         s <= n;
      end
   end

   // outputs straight from the state flops
   assign s_axi_awready      = s.aw_rdy;
   assign s_axi_wready       = s.w_rdy;
   assign s_axi_bvalid       = s.bvalid;
   assign s_axi_bresp        = s.bresp;
   assign s_axi_arready      = s.ar_rdy;
   assign s_axi_rvalid       = s.rvalid;
   assign s_axi_rdata        = s.rdata;
   assign s_axi_rresp        = s.rresp;
   assign guard_overflow_irq = s.wirq;
   assign fetch_trap_irq     = s.tirq;
   assign sys_reset_req      = s.rst_out;
   assign hf_osc_restart     = s.osc_out;

   // length of the current reset request, for checking only
   logic [5:0] a_len_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         a_len_q <= 6'h0;
      end else if (s.rst_out) begin
         a_len_q <= a_len_q + 6'h1;
      end else begin
         a_len_q <= 6'h0;
      end
   end

   a_rst_length: assert property (@(posedge clk) disable iff (rst) // R13
      $fell(s.rst_out) |-> $past(a_len_q) == 6'd23)
      else $error("reset request not 24 cycles long");
   a_rst_bound: assert property (@(posedge clk) disable iff (rst) // R13
      s.rst_out |-> a_len_q < 6'd24)
      else $error("reset request too long");
   a_off_clears: assert property (@(posedge clk) disable iff (rst) // R4
      !s.run |-> s.bin == 2'h0)
      else $error("counter moves while disabled");
   a_disable_ignored: assert property (@(posedge clk) disable iff (rst) // R3
      (wr_b && s.w_data == wdat_pkg::CODE_DISABLE && s.en_bit) |=> s.run)
      else $error("disable honoured with enable bit set");
   a_action_locked: assert property (@(posedge clk) disable iff (rst) // R8
      !s.ovf_sel |=> !s.ovf_sel)
      else $error("overflow action returned to reset");
   a_ovf_irq: assert property (@(posedge clk) disable iff (rst) // R7
      (ovf && !s.ovf_sel) |=> guard_overflow_irq ##1 !guard_overflow_irq)
      else $error("overflow interrupt missing or repeated");
   a_ovf_reset: assert property (@(posedge clk) disable iff (rst) // R12
      (ovf && s.ovf_sel && !s.rst_out) |=> sys_reset_req && !guard_overflow_irq)
      else $error("overflow reset missing");
   a_sfr_trap: assert property (@(posedge clk) disable iff (rst) // R18
      (fetch_valid && hit_sfr && !s.trap_act) |=> fetch_trap_irq)
      else $error("register area fetch did not trap");
   a_trap_reset: assert property (@(posedge clk) disable iff (rst) // R20
      (trap && s.trap_act && !s.rst_out) |=> sys_reset_req[*8])
      else $error("trap reset missing");
   a_ram_unarmed: assert property (@(posedge clk) disable iff (rst) // R16
      (fetch_valid && !hit_sfr && !s.trap_live) |=> !fetch_trap_irq)
      else $error("ram fetch trapped while unarmed");
   a_osc_restart: assert property (@(posedge clk) disable iff (rst) // R14
      (start_rst && low_speed_mode_1) |=> hf_osc_restart && sys_reset_req)
      else $error("oscillator restart missing");
   a_clear_bin: assert property (@(posedge clk) disable iff (rst) // R5
      clr_cmd |=> s.bin == 2'h0 && s.div == $past(s.div) + 24'h1
                  || !$past(src_en))
      else $error("clear code misbehaved");
   // event outputs, trap arming, run control, counter hold and field updates
   a_irq_cause: assert property (@(posedge clk) disable iff (rst) // R24
      guard_overflow_irq |-> $past(ovf) && !$past(s.ovf_sel))
      else $error("watchdog interrupt without overflow");
   a_trap_cause: assert property (@(posedge clk) disable iff (rst) // R24
      fetch_trap_irq |-> $past(trap) && !$past(s.trap_act))
      else $error("trap interrupt without trapped fetch");
   a_arm_copy: assert property (@(posedge clk) disable iff (rst) // R16
      (wr_b && s.w_data == wdat_pkg::CODE_ARM) |=>
         s.trap_live == $past(s.trap_stage))
      else $error("arm code did not copy ram trap enable");
   a_live_hold: assert property (@(posedge clk) disable iff (rst) // R16
      !(wr_b && s.w_data == wdat_pkg::CODE_ARM) |=> $stable(s.trap_live))
      else $error("ram trap enable changed without arm code");
   a_enable_run: assert property (@(posedge clk) disable iff (rst) // R1
      (wr_a && s.w_data[wdat_pkg::POS_EN_BIT]) |=> s.run)
      else $error("enable write did not start counting");
   a_disable_run: assert property (@(posedge clk) disable iff (rst) // R3
      (wr_b && s.w_data == wdat_pkg::CODE_DISABLE && !s.en_bit) |=>
         !s.run && s.bin == 2'h0)
      else $error("honoured disable did not stop and clear");
   a_bin_steady: assert property (@(posedge clk) disable iff (rst) // R4
      (s.run && n.run && !clr_cmd && !tick) |=> $stable(s.bin))
      else $error("binary counter moved without a tick");
   a_write_fields: assert property (@(posedge clk) disable iff (rst) // R15
      wr_a |=> s.period == $past(s.w_data[wdat_pkg::POS_PERIOD +: 2]) &&
               s.trap_act == $past(s.w_data[wdat_pkg::POS_TRAP_ACT]))
      else $error("control write did not set both field groups");
   a_ram_trap: assert property (@(posedge clk) disable iff (rst) // R19
      (fetch_valid && hit_ram && !s.trap_act) |=> fetch_trap_irq)
      else $error("armed ram fetch did not trap");
   a_trap_quiet: assert property (@(posedge clk) disable iff (rst) // R20
      (trap && s.trap_act) |=> !fetch_trap_irq)
      else $error("trap in reset mode raised an interrupt");
   a_osc_single: assert property (@(posedge clk) disable iff (rst) // R14
      hf_osc_restart |=> !hf_osc_restart)
      else $error("oscillator restart longer than one cycle");
   a_osc_cause: assert property (@(posedge clk) disable iff (rst) // R14
      hf_osc_restart |-> sys_reset_req)
      else $error("oscillator restart without reset request");
   a_osc_fast: assert property (@(posedge clk) disable iff (rst) // R14
      (start_rst && !low_speed_mode_1) |=> !hf_osc_restart)
      else $error("oscillator restart outside low speed mode");
endmodule
`default_nettype wire

// ===== verilog/wdat_pkg.sv
// constants and state type of the watchdog and address-trap block
package wdat_pkg;
   // register byte offsets on the bus
   localparam logic [7:0] OFF_CTRL_A = 8'h00;
   localparam logic [7:0] OFF_CMD_B  = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   // field positions of guard_control_reg_a
   localparam int POS_OVF_SEL    = 0;
   localparam int POS_PERIOD     = 1;
   localparam int POS_EN_BIT     = 3;
   localparam int POS_TRAP_ACT   = 4;
   localparam int POS_TRAP_EN    = 5;
   // reset values
   localparam logic       RST_OVF_SEL  = 1'b1;
   localparam logic [1:0] RST_PERIOD   = 2'h0;
   localparam logic       RST_EN_BIT   = 1'b1;
   localparam logic       RST_TRAP_ACT = 1'b1;
   localparam logic       RST_TRAP_EN  = 1'b1;
   // command codes of guard_command_reg_b
   localparam logic [7:0] CODE_CLEAR   = 8'h4E;
   localparam logic [7:0] CODE_DISABLE = 8'hB1;
   localparam logic [7:0] CODE_ARM     = 8'hD2;
   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // reset request length, in high-frequency clock periods
   localparam int         RST_FC_PERIODS = 24;
   localparam logic [4:0] RST_CYCLES     = 5'(RST_FC_PERIODS);
   // divider width: largest tick interval is 2**23 cycles
   localparam int DIV_W = 24;

   typedef struct packed {
      logic             aw_full;
      logic [7:0]       aw_addr;
      logic             w_full;
      logic [7:0]       w_data;
      logic             w_en;
      logic             aw_rdy;
      logic             w_rdy;
      logic             ar_rdy;
      logic             bvalid;
      logic [1:0]       bresp;
      logic             rvalid;
      logic [31:0]      rdata;
      logic [1:0]       rresp;
      logic             ovf_sel;
      logic             en_bit;
      logic [1:0]       period;
      logic             trap_act;
      logic             trap_stage;
      logic             trap_live;
      logic             run;
      logic [DIV_W-1:0] div;
      logic [1:0]       bin;
      logic [4:0]       rst_cnt;
      logic             rst_out;
      logic             osc_out;
      logic             wirq;
      logic             tirq;
   } wdat_state_t;
endpackage
